// file: common/drr_pkg.sv
package drr_pkg;
	// Command encodings on the decoded command bus
	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_MRS = 3'b001,
		CMD_ACT = 3'b010,
		CMD_WR = 3'b011,
		CMD_PRE = 3'b100,
		CMD_REF = 3'b101,
		CMD_RD = 3'b110
	} drr_cmd_e;

	// One command slot from the controller
	typedef struct packed {
		logic valid;
		drr_cmd_e cmd;
		logic [1:0] bg;
		logic [1:0] ba;
		logic [17:0] addr;
	} drr_cmd_s;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_HARD_KEY = 4'h1,
		ST_HARD_ARMED = 4'h2,
		ST_ACT = 4'h3,
		ST_WAIT_DATA = 4'h4,
		ST_SAMPLE = 4'h5,
		ST_PROGRAM = 4'h6,
		ST_DONE = 4'h7
	} drr_state_e;

	// Mode register field positions
	localparam int MR_HARD_BIT = 13;
	localparam int MR_SOFT_BIT = 5;
	localparam logic [1:0] MR_FOUR_ADDR = 2'h0;
	localparam logic [2:0] MR_SEL_ZERO = 3'h0;
	localparam logic [2:0] MR_SEL_FOUR = 3'h4;
	// Guard keys on address bits 11:7
	localparam logic [4:0] GUARD_KEY0 = 5'h19;
	localparam logic [4:0] GUARD_KEY1 = 5'h0f;
	localparam logic [4:0] GUARD_KEY2 = 5'h17;
	localparam logic [4:0] GUARD_KEY3 = 5'h07;
	// Data window: four clocks, eight burst bits
	localparam int DATA_CLKS = 4;
	localparam int HIGH_SKIP_CLKS = 2;
	// Identifier bit positions
	localparam int ID_HARD_POS = 7;
	localparam int ID_SOFT_POS = 6;
	localparam logic [7:0] ID_RESET = 8'h00;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int HARD_PGM_MS_X8 = 1000;
	localparam int HARD_PGM_MS_X16 = 2000;
	localparam longint HARD_PGM_CYC_X8 = (longint'(HARD_PGM_MS_X8) * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint HARD_PGM_CYC_X16 = (longint'(HARD_PGM_MS_X16) * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NUM_BG = 4;
endpackage : drr_pkg

// file: hdl/drr_soft_store.sv
`timescale 1ns/100ps
// Per bank group soft repair row store, registered read
module drr_soft_store
	import drr_pkg::*;
#(
	parameter int ROW_W = 18,
	parameter int BG_N = NUM_BG
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Write side
	input wire logic wr_en_i,
	input wire logic [1:0] wr_bg_i,
	input wire logic [1:0] wr_ba_i,
	input wire logic [ROW_W-1:0] wr_row_i,
	// Read side
	input wire logic [1:0] rd_bg_i,
	output logic rd_valid_o,
	output logic [1:0] rd_ba_o,
	output logic [ROW_W-1:0] rd_row_o
);
	logic [BG_N-1:0] valid_reg;
	logic [1:0] ba_reg [BG_N];
	logic [ROW_W-1:0] row_reg [BG_N];

	// One entry per bank group, new write replaces old
	genvar g;
	generate
		for (g = 0; g < BG_N; g++) begin : g_ent
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					valid_reg[g] <= 1'b0;
					ba_reg[g] <= 2'h0;
					row_reg[g] <= '0;
				end else if (wr_en_i && wr_bg_i == 2'(g)) begin
					valid_reg[g] <= 1'b1;
					ba_reg[g] <= wr_ba_i;
					row_reg[g] <= wr_row_i;
				end
			end
		end
	endgenerate

	// Registered read port
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_valid_o <= 1'b0;
			rd_ba_o <= 2'h0;
			rd_row_o <= '0;
		end else begin
			rd_valid_o <= valid_reg[rd_bg_i];
			rd_ba_o <= ba_reg[rd_bg_i];
			rd_row_o <= row_reg[rd_bg_i];
		end
	end
endmodule : drr_soft_store

// file: hdl/drr_row_repair_seq.sv
`timescale 1ns/100ps
// Functional notes
// - Repair only if every data line low in all eight burst bits.
// - Data all high two or more clocks skips repair; other patterns undefined.
// - Soft repair enabled while mode register four bit 5 is one and bit 13 is zero.
// - Soft repairs persist until reset or rewrite of same bank group.
// - One soft row per bank group; new repair replaces old.
// - Bank group with used-up hard resources ignores repair sequences.
// - Identifier byte reports hard availability at bit 7, soft at bit 6.
module drr_row_repair_seq
	import drr_pkg::*;
#(
	parameter int DQ_W = 8,
	parameter int ROW_W = 18,
	parameter int WL_MAX = 32,
	parameter bit WIDE_X16 = 1'b0,
	parameter longint HARD_PGM_CYC = WIDE_X16 ? HARD_PGM_CYC_X16 : HARD_PGM_CYC_X8,
	parameter logic HARD_SUPPORTED = 1'b1,
	parameter logic SOFT_SUPPORTED = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Command bus from controller
	input wire drr_cmd_s cmd_i,
	input wire logic [5:0] write_latency_i,
	// Data pins (already synchronous to clk)
	input wire logic [DQ_W-1:0] dq_rise_i,
	input wire logic [DQ_W-1:0] dq_fall_i,
	// Per bank group hard resource state
	input wire logic [NUM_BG-1:0] hard_spent_i,
	// Repair outputs
	output logic hard_mode_o,
	output logic soft_mode_o,
	output logic hard_fire_o,
	output logic [1:0] fire_bg_o,
	output logic [1:0] fire_ba_o,
	output logic [ROW_W-1:0] fire_row_o,
	output logic [7:0] repair_support_identifier_o,
	output logic [1:0] lookup_ba_o,
	output logic [ROW_W-1:0] lookup_row_o,
	output logic lookup_valid_o
);
	drr_state_e state_reg, state_next;
	logic hard_mode_reg;
	logic soft_mode_reg;
	logic [1:0] key_idx_reg;
	logic [1:0] bg_reg;
	logic [1:0] ba_reg;
	logic [ROW_W-1:0] row_reg;
	logic [5:0] wl_cnt_reg;
	logic [2:0] data_cnt_reg;
	logic all_low_reg;
	logic [2:0] high_run_reg;
	logic soft_wr_reg;
	logic [63:0] pgm_cnt_reg;

	// Command decode
	wire is_mrs = cmd_i.valid && cmd_i.cmd == CMD_MRS;
	wire mrs_four = is_mrs && cmd_i.addr[17:15] == MR_SEL_FOUR;
	wire mrs_zero = is_mrs && cmd_i.addr[17:15] == MR_SEL_ZERO;
	wire is_act = cmd_i.valid && cmd_i.cmd == CMD_ACT;
	wire is_wr = cmd_i.valid && cmd_i.cmd == CMD_WR;
	wire is_pre = cmd_i.valid && cmd_i.cmd == CMD_PRE;
	wire other_cmd = cmd_i.valid && !mrs_zero && !mrs_four;
	wire hard_bit = cmd_i.addr[MR_HARD_BIT];
	wire soft_bit = cmd_i.addr[MR_SOFT_BIT];
	wire [4:0] key_field = cmd_i.addr[11:7];
	wire [4:0] key_want = key_idx_reg == 2'd0 ? GUARD_KEY0 :
		key_idx_reg == 2'd1 ? GUARD_KEY1 :
		key_idx_reg == 2'd2 ? GUARD_KEY2 : GUARD_KEY3;
	wire key_ok = mrs_zero && key_field == key_want;
	// Data sample: all low both edges, all high both edges
	wire beat_low = ~|dq_rise_i && ~|dq_fall_i;
	wire beat_high = &dq_rise_i && &dq_fall_i;
	wire data_last = data_cnt_reg == 3'(DATA_CLKS - 1);
	wire repair_ok = all_low_reg && beat_low;
	wire skip_high = high_run_reg >= 3'(HIGH_SKIP_CLKS);
	wire pgm_done = soft_wr_reg || pgm_cnt_reg >= 64'(HARD_PGM_CYC);

	// Next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (mrs_four && hard_bit && !soft_bit) begin
					state_next = ST_HARD_KEY;
				end else if (mrs_four && soft_bit && !hard_bit) begin
					state_next = ST_ACT;
				end
			end
			ST_HARD_KEY: begin
				if (mrs_four && !hard_bit) begin
					state_next = ST_IDLE;
				end else if (key_ok && key_idx_reg == 2'd3) begin
					state_next = ST_HARD_ARMED;
				end else if (other_cmd || (mrs_zero && !key_ok)) begin
					state_next = ST_DONE;
				end
			end
			ST_HARD_ARMED, ST_ACT: begin
				if (mrs_four && !hard_bit && !soft_bit) begin
					state_next = ST_IDLE;
				end else if (is_act) begin
					state_next = hard_spent_i[cmd_i.bg] ? ST_DONE : ST_WAIT_DATA;
				end
			end
			ST_WAIT_DATA: begin
				if (is_wr && cmd_i.bg == bg_reg && cmd_i.ba == ba_reg) begin
					state_next = ST_SAMPLE;
				end else if (is_pre) begin
					state_next = ST_DONE;
				end
			end
			ST_SAMPLE: begin
				if (wl_cnt_reg == 6'h0 && data_last) begin
					state_next = (repair_ok && !skip_high) ? ST_PROGRAM : ST_DONE;
				end
			end
			ST_PROGRAM: begin
				if (is_pre) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				if (mrs_four && !hard_bit && !soft_bit) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= ST_IDLE;
			key_idx_reg <= 2'd0;
		end else begin
			state_reg <= state_next;
			// Index survives idle slots between keys, restarts outside key entry
			key_idx_reg <= (state_reg != ST_HARD_KEY) ? 2'd0 : key_ok ? key_idx_reg + 2'd1 : key_idx_reg;
		end
	end

	// Mode bits follow mode register four writes
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hard_mode_reg <= 1'b0;
			soft_mode_reg <= 1'b0;
		end else if (mrs_four) begin
			hard_mode_reg <= hard_bit && !soft_bit;
			soft_mode_reg <= soft_bit && !hard_bit;
		end
	end

	// Capture target from activate, write latency count
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bg_reg <= 2'h0;
			ba_reg <= 2'h0;
			row_reg <= '0;
			soft_wr_reg <= 1'b0;
			wl_cnt_reg <= 6'h0;
		end else begin
			if (is_act && (state_reg == ST_HARD_ARMED || state_reg == ST_ACT)) begin
				bg_reg <= cmd_i.bg;
				ba_reg <= cmd_i.ba;
				row_reg <= cmd_i.addr[ROW_W-1:0];
				soft_wr_reg <= state_reg == ST_ACT;
			end
			if (state_next == ST_SAMPLE && state_reg == ST_WAIT_DATA) begin
				wl_cnt_reg <= write_latency_i;
			end else if (state_reg == ST_SAMPLE && wl_cnt_reg != 6'h0) begin
				wl_cnt_reg <= wl_cnt_reg - 6'h1;
			end
		end
	end

	// Data window check over four clocks
	always_ff @(posedge clk_i) begin
		if (srst_i || state_reg != ST_SAMPLE || wl_cnt_reg != 6'h0) begin
			data_cnt_reg <= 3'h0;
			all_low_reg <= 1'b1;
			high_run_reg <= 3'h0;
		end else begin
			data_cnt_reg <= data_cnt_reg + 3'h1;
			all_low_reg <= all_low_reg && beat_low;
			high_run_reg <= beat_high ? high_run_reg + 3'h1 : 3'h0;
		end
	end

	// Program time counter
	always_ff @(posedge clk_i) begin
		if (srst_i || state_reg != ST_PROGRAM) begin
			pgm_cnt_reg <= 64'h0;
		end else if (!pgm_done) begin
			pgm_cnt_reg <= pgm_cnt_reg + 64'h1;
		end
	end

	// Repair fire pulse at precharge after programming
	wire fire = state_reg == ST_PROGRAM && is_pre && pgm_done;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hard_mode_o <= 1'b0;
			soft_mode_o <= 1'b0;
			hard_fire_o <= 1'b0;
			fire_bg_o <= 2'h0;
			fire_ba_o <= 2'h0;
			fire_row_o <= '0;
			repair_support_identifier_o <= ID_RESET;
		end else begin
			hard_mode_o <= hard_mode_reg;
			soft_mode_o <= soft_mode_reg;
			hard_fire_o <= fire && !soft_wr_reg;
			fire_bg_o <= bg_reg;
			fire_ba_o <= ba_reg;
			fire_row_o <= row_reg;
			repair_support_identifier_o <= ID_RESET;
			repair_support_identifier_o[ID_HARD_POS] <= HARD_SUPPORTED;
			repair_support_identifier_o[ID_SOFT_POS] <= SOFT_SUPPORTED;
		end
	end

	// Soft repair store
	drr_soft_store #(
		.ROW_W(ROW_W),
		.BG_N(NUM_BG)
	) u_store (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.wr_en_i(fire && soft_wr_reg),
		.wr_bg_i(bg_reg),
		.wr_ba_i(ba_reg),
		.wr_row_i(row_reg),
		.rd_bg_i(cmd_i.bg),
		.rd_valid_o(lookup_valid_o),
		.rd_ba_o(lookup_ba_o),
		.rd_row_o(lookup_row_o)
	);
endmodule : drr_row_repair_seq

// file: tb/drr_row_repair_seq_assertions.sv
`timescale 1ns/100ps
// Port-level checks on modes, commit pulse and identifier
module drr_row_repair_seq_assertions
	import drr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Controller side
	input wire drr_cmd_s cmd_i,
	input wire logic [NUM_BG-1:0] hard_spent_i,
	// Repair outputs
	input wire logic hard_mode_o,
	input wire logic soft_mode_o,
	input wire logic hard_fire_o,
	input wire logic [1:0] fire_bg_o,
	input wire logic [7:0] repair_support_identifier_o,
	input wire logic lookup_valid_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Decoded mode register four write and precharge
	wire mrs4_w = cmd_i.valid && cmd_i.cmd == CMD_MRS && cmd_i.addr[17:15] == MR_SEL_FOUR;
	wire pre_w = cmd_i.valid && cmd_i.cmd == CMD_PRE;
	sequence s_soft_on;
		mrs4_w && cmd_i.addr[MR_SOFT_BIT] && !cmd_i.addr[MR_HARD_BIT];
	endsequence
	sequence s_both_on;
		mrs4_w && cmd_i.addr[MR_SOFT_BIT] && cmd_i.addr[MR_HARD_BIT];
	endsequence
	// Mode pins pass a mode flop and an output flop, so they follow the write two edges later
	AST_SOFT_ON: assert property (s_soft_on |-> ##2 (soft_mode_o && !hard_mode_o))
		else $error("soft mode not entered");
	AST_SOFT_OFF: assert property (mrs4_w && !cmd_i.addr[MR_SOFT_BIT] |-> ##2 !soft_mode_o)
		else $error("soft mode not left");
	AST_BOTH_OFF: assert property (s_both_on |-> ##2 (!soft_mode_o && !hard_mode_o))
		else $error("both modes accepted");
	AST_MODE_HOLD: assert property (!mrs4_w |-> ##2 ($stable(soft_mode_o) && $stable(hard_mode_o)))
		else $error("mode changed without write");
	AST_FIRE_PRE: assert property (hard_fire_o |-> $past(pre_w) && hard_mode_o)
		else $error("commit without precharge");
	AST_FIRE_ONE: assert property (hard_fire_o |=> !hard_fire_o)
		else $error("commit pulse too long");
	AST_SPENT: assert property (hard_fire_o |-> !hard_spent_i[fire_bg_o])
		else $error("commit to spent group");
	AST_ID: assert property (!$past(srst_i) |-> repair_support_identifier_o == 8'hc0)
		else $error("identifier wrong");
	AST_CLEAR: assert property ($past(srst_i) |-> !lookup_valid_o)
		else $error("soft store survived reset");
endmodule : drr_row_repair_seq_assertions

bind drr_row_repair_seq drr_row_repair_seq_assertions u_chk (.clk_i, .srst_i, .cmd_i, .hard_spent_i,
	.hard_mode_o, .soft_mode_o, .hard_fire_o, .fire_bg_o, .repair_support_identifier_o, .lookup_valid_o);

// file: tb/drr_ctrl_model.sv
`timescale 1ns/100ps
// Behavioural memory controller issuing repair flows
module drr_ctrl_model
	import drr_pkg::*;
#(
	parameter int DQ_W = 8,
	parameter int WL = 4
) (
	// Clock
	input wire logic clk_i,
	// Command and data to the device
	output drr_cmd_s cmd_o,
	output logic [DQ_W-1:0] dq_rise_o,
	output logic [DQ_W-1:0] dq_fall_o
);
	// Hard mode exit wait, 50 us at a 100 ns clock
	localparam int EXIT_WAIT = 500;
	// Idle bus, data held high
	initial begin
		cmd_o = '0;
		dq_rise_o = '1;
		dq_fall_o = '1;
	end
	// One command, then an idle clock; refresh is never sent
	task automatic issue(input drr_cmd_e c, input logic [1:0] bg, input logic [1:0] ba, input logic [17:0] a);
		@(negedge clk_i);
		cmd_o <= {1'b1, c, bg, ba, a};
		@(negedge clk_i);
		cmd_o.valid <= 1'b0;
	endtask : issue
	// Whole flow; bad 1 puts one high bit, bad 2 holds all high
	task automatic repair(input logic hard, input logic [1:0] bg, input logic [1:0] ba,
		input logic [17:0] row, input int bad, input int pgm);
		logic [4:0] keys [4] = '{GUARD_KEY0, GUARD_KEY1, GUARD_KEY2, GUARD_KEY3};
		issue(CMD_MRS, 2'h0, 2'h0, hard ? 18'h22000 : 18'h20020);
		if (hard) begin
			foreach (keys[i]) issue(CMD_MRS, 2'h0, 2'h0, {6'h0, keys[i], 7'h7f});
		end
		issue(CMD_ACT, bg, ba, row);
		issue(CMD_WR, bg, ba, 18'h0);
		repeat (WL) @(negedge clk_i);
		for (int k = 0; k < DATA_CLKS; k++) begin
			dq_rise_o <= (bad == 2) ? '1 : '0;
			dq_fall_o <= (bad == 2) ? '1 : (bad == 1 && k == 3) ? DQ_W'(1) : '0;
			@(negedge clk_i);
		end
		dq_rise_o <= '1;
		dq_fall_o <= '1;
		repeat (pgm) @(negedge clk_i);
		issue(CMD_PRE, bg, ba, 18'h0);
		issue(CMD_MRS, 2'h0, 2'h0, 18'h20000);
		if (hard) begin
			repeat (EXIT_WAIT) @(negedge clk_i);
			issue(CMD_MRS, 2'h0, 2'h0, 18'h0);
		end
	endtask : repair
	// Point the idle bus at a bank group for lookup
	task automatic look(input logic [1:0] bg);
		@(negedge clk_i);
		cmd_o.bg <= bg;
		@(negedge clk_i);
	endtask : look
endmodule : drr_ctrl_model

// file: tb/drr_row_repair_seq_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the row repair sequencer
module drr_row_repair_seq_tb
	import drr_pkg::*;
;
	localparam int PGM = 20;
	localparam int WL = 4;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [NUM_BG-1:0] hard_spent = '0;
	drr_cmd_s cmd;
	logic [7:0] dq_rise;
	logic [7:0] dq_fall;
	logic hard_mode;
	logic soft_mode;
	logic hard_fire;
	logic [1:0] fire_bg;
	logic [1:0] fire_ba;
	logic [17:0] fire_row;
	logic [7:0] ident;
	logic [1:0] lk_ba;
	logic [17:0] lk_row;
	logic lk_valid;
	int fails = 0;
	int n_tests = 0;
	int n_fire = 0;
	logic [21:0] fire_tgt;

	drr_row_repair_seq #(.HARD_PGM_CYC(PGM)) u_drr_row_repair_seq (.clk_i(clk_i), .srst_i(srst_i), .cmd_i(cmd),
		.write_latency_i(6'(WL)), .dq_rise_i(dq_rise), .dq_fall_i(dq_fall), .hard_spent_i(hard_spent),
		.hard_mode_o(hard_mode), .soft_mode_o(soft_mode), .hard_fire_o(hard_fire), .fire_bg_o(fire_bg),
		.fire_ba_o(fire_ba), .fire_row_o(fire_row), .repair_support_identifier_o(ident),
		.lookup_ba_o(lk_ba), .lookup_row_o(lk_row), .lookup_valid_o(lk_valid));
	drr_ctrl_model #(.WL(WL)) u_drr_ctrl_model (.clk_i(clk_i), .cmd_o(cmd), .dq_rise_o(dq_rise),
		.dq_fall_o(dq_fall));

	// Clock
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	// Count commit pulses and keep the last target
	always @(posedge clk_i) begin
		if (hard_fire === 1'b1) begin
			n_fire <= n_fire + 1;
			fire_tgt <= {fire_bg, fire_ba, fire_row};
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	// Identifier after reset; both enables together give neither
	task automatic t_idle();
		check("identifier", 8'hc0, ident);
		u_drr_ctrl_model.issue(CMD_MRS, 2'h0, 2'h0, 18'h20020);
		@(negedge clk_i);
		check("soft mode", 2'h1, {hard_mode, soft_mode});
		u_drr_ctrl_model.issue(CMD_MRS, 2'h0, 2'h0, 18'h22020);
		@(negedge clk_i);
		check("both modes", 2'h0, {hard_mode, soft_mode});
		u_drr_ctrl_model.issue(CMD_MRS, 2'h0, 2'h0, 18'h20000);
	endtask : t_idle
	// Faulty data, spent group and early precharge all refused
	task automatic t_hard_refused();
		int n0 = n_fire;
		u_drr_ctrl_model.repair(1'b1, 2'h0, 2'h1, 18'h00011, 1, PGM + 10);
		check("one high bit", n0, n_fire);
		u_drr_ctrl_model.repair(1'b1, 2'h0, 2'h1, 18'h00011, 2, PGM + 10);
		check("all high", n0, n_fire);
		hard_spent <= 4'h8;
		u_drr_ctrl_model.repair(1'b1, 2'h3, 2'h0, 18'h00022, 0, PGM + 10);
		check("spent group", n0, n_fire);
		hard_spent <= 4'h0;
		u_drr_ctrl_model.repair(1'b1, 2'h3, 2'h0, 18'h00022, 0, 2);
		check("early precharge", n0, n_fire);
	endtask : t_hard_refused
	// Clean hard repair commits the activated row
	task automatic t_hard_ok();
		int n0 = n_fire;
		u_drr_ctrl_model.repair(1'b1, 2'h1, 2'h2, 18'h2a5c3, 0, PGM + 10);
		check("hard commits", n0 + 1, n_fire);
		check("hard target", {2'h1, 2'h2, 18'h2a5c3}, fire_tgt);
	endtask : t_hard_ok
	// One soft row per group, newest wins, reset clears
	task automatic t_soft();
		int n0 = n_fire;
		u_drr_ctrl_model.repair(1'b0, 2'h2, 2'h1, 18'h13579, 0, 2);
		u_drr_ctrl_model.look(2'h2);
		check("soft row", {1'b1, 2'h1, 18'h13579}, {lk_valid, lk_ba, lk_row});
		u_drr_ctrl_model.repair(1'b0, 2'h2, 2'h3, 18'h02468, 0, 2);
		u_drr_ctrl_model.look(2'h2);
		check("soft replace", {1'b1, 2'h3, 18'h02468}, {lk_valid, lk_ba, lk_row});
		check("soft no commit", n0, n_fire);
		u_drr_ctrl_model.look(2'h1);
		check("other group", 1'b0, lk_valid);
		hard_spent <= 4'h1;
		u_drr_ctrl_model.repair(1'b0, 2'h0, 2'h2, 18'h00abc, 0, 2);
		hard_spent <= 4'h0;
		u_drr_ctrl_model.look(2'h0);
		check("soft spent", 1'b0, lk_valid);
		srst_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		srst_i <= 1'b0;
		u_drr_ctrl_model.look(2'h2);
		check("reset clears", 1'b0, lk_valid);
	endtask : t_soft
	task automatic conclude();
		if (fails == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	// Watchdog, far beyond the expected few thousand cycles
	initial begin
		#2000000;
		fails++;
		conclude();
	end
	// Main sequence
	initial begin
		repeat (20) @(negedge clk_i);
		srst_i <= 1'b0;
		@(negedge clk_i);
		t_idle();
		t_hard_refused();
		t_hard_ok();
		t_hard_ok();
		t_soft();
		conclude();
	end
endmodule : drr_row_repair_seq_tb
